// *** verilog/bci_irq_conf.sv ***
// Interrupt mask, status, acknowledge and build configuration registers on APB
//
// Contract
// - Base-time irq when counter matches select bit
// - Control bit 15 gates base-time during events
// - Nine mask bits gate their sources
// - Mask reset: upper four zero, lower five one
// - Status bit is pending and enabled; reserved zero
// - Same source positions in mask and status
// - Level mode flag bit 4 reads one
// - Bits 29:24 read address width 0xE
// - Bits 22:16 read on-chip radio code
// - Bits 13:8 mirror core clock select
// - Bit 0 reads one for 32-bit bus
// - Capability flags bits 1,2 one; 3,5 zero
// - Writing one to ack clears both flags
// - Raw flag pending regardless of mask
`timescale 1ns/1ps
`default_nettype none
`include "bci_map.svh"

module bci_irq_conf (
  input wire logic pclk, // System clock, 125 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address, write to a read-only register or read of ack
  input wire bci_pkg::bci_src_t src_event, // One-cycle event pulses per source
  input wire logic [3:0] slot_counter, // Current slot counter value
  input wire logic in_event, // Advertising, scan, initiate or connection active
  input wire logic [5:0] core_clock_select, // Operating frequency in MHz
  output logic irq // Combined level interrupt
);

  bci_pkg::bci_ctrl_t ctrl_reg;
  bci_pkg::bci_ctrl_t ctrl_next;
  bci_pkg::bci_src_t raw_reg;
  bci_pkg::bci_src_t raw_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  bci_pkg::bci_phase_t phase_reg;
  bci_pkg::bci_phase_t phase_next;

  // Address compare is shared by every register select
  function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] offset);
    return addr == offset;
  endfunction

  // Masked view of the pending flags, used by the read path and the irq register
  function automatic logic [8:0] masked_pending(input bci_pkg::bci_src_t raw,
      input bci_pkg::bci_src_t mask);
    return raw & mask;
  endfunction

  wire setup = psel && !penable;
  wire access = psel && penable;
  // First access cycle: read data is latched here so that it stands with pready
  wire done = access && (phase_reg == bci_pkg::BCI_SETUP);
  // Completion cycle: writes land on the edge at which the master sees pready
  wire commit = access && pready_reg;
  wire sel_conf = addr_hit(paddr, `BCI_OFF_CONF);
  wire sel_mask = addr_hit(paddr, `BCI_OFF_MASK);
  wire sel_stat = addr_hit(paddr, `BCI_OFF_STAT);
  wire sel_raw = addr_hit(paddr, `BCI_OFF_RAW);
  wire sel_ack = addr_hit(paddr, `BCI_OFF_ACK);
  wire mapped = sel_conf || sel_mask || sel_stat || sel_raw || sel_ack;
  // Read-only registers refuse writes, ack refuses reads
  wire bad = !mapped || (pwrite && (sel_conf || sel_stat || sel_raw)) || (!pwrite && sel_ack);
  // Writes wait for completion so that an abandoned transfer leaves no trace
  wire wr_ok = commit && pwrite && !bad;
  wire wr_mask = wr_ok && sel_mask;
  wire wr_ack = wr_ok && sel_ack;

  wire cs_match = ctrl_reg.slot_counter_irq_select[slot_counter];
  wire cs_allowed = ctrl_reg.base_time_irq_during_event_enable || !in_event;

  bci_pkg::bci_src_t fire;
  always_comb begin
    fire = src_event;
    fire.base_time = src_event.base_time && cs_match && cs_allowed;
  end

  wire [8:0] ack_bits = wr_ack ? pwdata[`BCI_MASK_MSB:0] : 9'h000;
  // raw pending, set wins over acknowledge
  assign raw_next = bci_pkg::bci_src_t'((raw_reg & ~ack_bits) | fire);

  wire [8:0] status = masked_pending(raw_reg, ctrl_reg.mask);
  wire [8:0] status_next = masked_pending(raw_next, ctrl_next.mask);

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_mask) begin
      ctrl_next.slot_counter_irq_select = pwdata[`BCI_SEL_MSB:`BCI_SEL_LSB];
      ctrl_next.base_time_irq_during_event_enable = pwdata[`BCI_DURING_EVT_BIT];
      ctrl_next.mask = bci_pkg::bci_src_t'(pwdata[`BCI_MASK_MSB:0]);
    end
  end

  wire [31:0] conf_word = {2'h0, `BCI_ADDR_WIDTH_CODE, 1'h0, `BCI_RF_IF_CODE, 2'h0,
    core_clock_select, 2'h0, `BCI_DUAL_MODE, `BCI_LEVEL_MODE, `BCI_COEX, `BCI_DIAG,
    `BCI_CIPHER, `BCI_BUS32};
  wire [31:0] mask_word = {ctrl_reg.slot_counter_irq_select,
    ctrl_reg.base_time_irq_during_event_enable, 6'h00, ctrl_reg.mask};

  assign prdata_next = !(done && !pwrite && !bad) ? 32'h00000000 :
    sel_conf ? conf_word : sel_mask ? mask_word :
    sel_stat ? {23'h000000, status} : {23'h000000, raw_reg};

  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      bci_pkg::BCI_IDLE: if (setup) phase_next = bci_pkg::BCI_SETUP;
      bci_pkg::BCI_SETUP: if (access) phase_next = bci_pkg::BCI_ACCESS;
      bci_pkg::BCI_ACCESS: phase_next = setup ? bci_pkg::BCI_SETUP : bci_pkg::BCI_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= {`BCI_SEL_RST, `BCI_DURING_EVT_RST, `BCI_MASK_RST};
      raw_reg <= '0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'h0;
      pslverr_reg <= 1'h0;
      irq_reg <= 1'h0;
      phase_reg <= bci_pkg::BCI_IDLE;
    end else begin
      ctrl_reg <= ctrl_next;
      raw_reg <= raw_next;
      prdata_reg <= prdata_next;
      pready_reg <= done;
      pslverr_reg <= done && bad;
      irq_reg <= |status_next;
      phase_reg <= phase_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

  // Assertions, all on the bus clock and quiet during reset

  mask_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> ctrl_reg.mask == `BCI_MASK_RST)
    else $error("mask reset value wrong");

  sel_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> ctrl_reg.slot_counter_irq_select == `BCI_SEL_RST)
    else $error("select reset value wrong");

  evt_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> ctrl_reg.base_time_irq_during_event_enable == `BCI_DURING_EVT_RST)
    else $error("event enable reset value wrong");

  mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_mask |=> ctrl_reg.mask == $past(pwdata[8:0]))
    else $error("mask not written");

  sel_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_mask |=> ctrl_reg.slot_counter_irq_select == $past(pwdata[31:16]))
    else $error("select not written");

  evt_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_mask |=> ctrl_reg.base_time_irq_during_event_enable == $past(pwdata[15]))
    else $error("event enable not written");

  // Refused write has no effect
  bad_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && bad |=> ctrl_reg == $past(ctrl_reg))
    else $error("refused write changed control");

  status_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    status == (raw_reg & ctrl_reg.mask))
    else $error("status not masked raw");

  raw_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    fire.receive |=> raw_reg.receive)
    else $error("raw flag not set");

  raw_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
    fire != 9'h000 |=> (raw_reg & $past(fire)) == $past(fire))
    else $error("event not latched");

  raw_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ack |=> (raw_reg & $past(raw_reg)) == $past(raw_reg))
    else $error("raw flag dropped without ack");

  raw_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_mask |=> raw_reg == ($past(raw_reg) | $past(fire)))
    else $error("mask write disturbed raw flags");

  ack_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ack && pwdata[0] && !fire.base_time |=> !raw_reg.base_time && !status[0])
    else $error("ack did not clear");

  ack_rx_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ack && pwdata[1] && !fire.receive |=> !raw_reg.receive && !status[1])
    else $error("receive ack did not clear");

  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ack && fire.radio_ctrl |=> raw_reg.radio_ctrl)
    else $error("ack beat a new event");

  ack_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && sel_ack |=> pslverr && prdata == 32'h00000000)
    else $error("ack read not refused");

  cs_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    src_event.base_time && !ctrl_reg.slot_counter_irq_select[slot_counter]
    && !raw_reg.base_time |=> !raw_reg.base_time)
    else $error("unselected count fired");

  cs_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
    src_event.base_time && ctrl_reg.slot_counter_irq_select[slot_counter]
    && (ctrl_reg.base_time_irq_during_event_enable || !in_event) |=> raw_reg.base_time)
    else $error("selected count did not fire");

  event_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_event && !ctrl_reg.base_time_irq_during_event_enable |-> !fire.base_time)
    else $error("base time in event");

  event_allow_a: assert property (@(posedge pclk) disable iff (!presetn)
    src_event.base_time && in_event && ctrl_reg.base_time_irq_during_event_enable
    && ctrl_reg.slot_counter_irq_select[slot_counter] |-> fire.base_time)
    else $error("base time blocked in event");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (|status))
    else $error("irq not equal any status");

  irq_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ack && pwdata[8:0] == 9'h1FF && fire == 9'h000 |=> !irq)
    else $error("irq stayed after full ack");

  conf_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && sel_conf |=> prdata[29:0] == {6'h0E, 1'h0, 7'h08, 2'h0,
    $past(core_clock_select), 8'h17})
    else $error("config word wrong");

  conf_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && sel_conf |=> prdata[31:30] == 2'h0 && !prdata[23])
    else $error("config reserved bits set");

  level_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && sel_conf |=> prdata[4])
    else $error("level mode flag low");

  radio_if_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && sel_conf |=> prdata[22:16] == 7'h08)
    else $error("radio interface code wrong");

  clk_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && sel_conf |=> prdata[13:8] == $past(core_clock_select))
    else $error("clock select not mirrored");

  bus_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && sel_conf |=> prdata[0])
    else $error("bus width flag low");

  cap_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && sel_conf |=> {prdata[5], prdata[3:1]} == 4'h3)
    else $error("capability flags wrong");

  mask_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && sel_mask |=> prdata[8:0] == $past(ctrl_reg.mask))
    else $error("mask read positions wrong");

  stat_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && sel_stat |=> prdata == {23'h000000, $past(raw_reg & ctrl_reg.mask)})
    else $error("status read wrong");

  raw_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && sel_raw |=> prdata == {23'h000000, $past(raw_reg)})
    else $error("raw read wrong");

  // One wait state always
  ready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup ##1 access |=> pready)
    else $error("no ready after access");

  // Unmapped address refused
  slverr_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !mapped |=> pslverr)
    else $error("unmapped access not refused");

  // Read data zero outside completion
  idle_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h00000000)
    else $error("read data outside completion");

  // Main scenarios
  cov_ack_c: cover property (@(posedge pclk) disable iff (!presetn) irq ##[1:20] !irq);
  cov_cs_c: cover property (@(posedge pclk) disable iff (!presetn) fire.base_time);
  cov_err_c: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  cov_event_c: cover property (@(posedge pclk) disable iff (!presetn) in_event && fire.base_time);
  cov_wins_c: cover property (@(posedge pclk) disable iff (!presetn) wr_ack && fire != 9'h000);

endmodule // bci_irq_conf
`default_nettype wire

// *** verilog/bci_map.svh ***
// Register offsets, field positions, reset values and fixed build codes
`ifndef BCI_MAP_SVH
`define BCI_MAP_SVH

`define BCI_OFF_CONF 32'h40000008
`define BCI_OFF_MASK 32'h4000000C
`define BCI_OFF_STAT 32'h40000010
`define BCI_OFF_RAW 32'h40000014
`define BCI_OFF_ACK 32'h40000018

`define BCI_NSRC 9
`define BCI_SEL_LSB 16
`define BCI_SEL_MSB 31
`define BCI_DURING_EVT_BIT 15
`define BCI_MASK_MSB 8

`define BCI_SEL_RST 16'h00FF
`define BCI_DURING_EVT_RST 1'h1
`define BCI_MASK_RST 9'h01F

`define BCI_ADDR_WIDTH_CODE 6'h0E
`define BCI_RF_IF_CODE 7'h08
`define BCI_DUAL_MODE 1'h0
`define BCI_LEVEL_MODE 1'h1
`define BCI_COEX 1'h0
`define BCI_DIAG 1'h1
`define BCI_CIPHER 1'h1
`define BCI_BUS32 1'h1

`endif

// *** verilog/bci_pkg.sv ***
// Types shared by the interrupt and configuration block
package bci_pkg;

  typedef struct packed {
    logic radio_ctrl;
    logic fine_target_timer;
    logic gross_target_timer;
    logic fault;
    logic cipher;
    logic end_of_event;
    logic sleep_end;
    logic receive;
    logic base_time;
  } bci_src_t;

  typedef struct packed {
    logic [15:0] slot_counter_irq_select;
    logic base_time_irq_during_event_enable;
    bci_src_t mask;
  } bci_ctrl_t;

  typedef enum logic [1:0] {
    BCI_IDLE,
    BCI_SETUP,
    BCI_ACCESS
  } bci_phase_t;

endpackage

// *** testbench/bci_cpu_model.sv ***
// APB master standing in for the processor core
`timescale 1ns/1ps
`default_nettype none
module bci_cpu_model (
  input wire logic pclk, // Clock
  input wire logic pready, // Slave ready
  input wire logic [31:0] prdata, // Read data
  output logic psel, // Select
  output logic penable, // Access phase
  output logic pwrite, // Direction
  output logic [31:0] paddr, // Address
  output logic [31:0] pwdata // Write data
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Request held until pready is seen high; the wait is bounded so a hang ends the run
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic to);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // bci_cpu_model
`default_nettype wire

// *** testbench/ble_core_irq_and_config_tb.sv ***
// Self-checking bench for the interrupt and build configuration block
`timescale 1ns/1ps
`default_nettype none
module ble_core_irq_and_config_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, to;
  logic in_event = 1'b0;
  logic [31:0] paddr, pwdata, prdata, rd, m;
  logic [3:0] slot_counter = 4'h0;
  logic [5:0] core_clock_select = 6'h00;
  logic [8:0] ev;
  bci_pkg::bci_src_t src_event = '0;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int n_mismatch = 0;
  int n_checks = 0;
  always #4 pclk = ~pclk;
  bci_irq_conf u_bci_irq_conf (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_event(src_event),
    .slot_counter(slot_counter), .in_event(in_event),
    .core_clock_select(core_clock_select), .irq(irq));
  bci_cpu_model u_bci_cpu_model (.pclk(pclk), .pready(pready), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic chk(input logic [32:0] got, input logic [32:0] want);
    n_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Expected {pslverr, prdata} is queued before the transfer starts
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d,
      input logic [32:0] want);
    exp_q.push_back(want);
    u_bci_cpu_model.xfer(w, a, d, rd, to);
    if (to) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic pulse(input logic [8:0] v);
    @(posedge pclk);
    src_event <= bci_pkg::bci_src_t'(v);
    @(posedge pclk);
    src_event <= '0;
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1FFFFFFFF;
      chk({pslverr, prdata}, e);
    end
  end
  initial begin
    void'($urandom(32'h026275EB));
    core_clock_select = 6'($urandom);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    acc(0, 32'h40000008, 0, {9'h00E, 1'b0, 7'h08, 2'h0, core_clock_select, 8'h17});
    acc(0, 32'h4000000C, 0, 33'h000FF801F);
    acc(0, 32'h40000010, 0, 33'h0);
    acc(1, 32'h40000008, 32'hFFFFFFFF, 33'h100000000);
    acc(0, 32'h40000018, 0, 33'h100000000);
    acc(0, 32'h40000020, 0, 33'h100000000);
    for (int i = 0; i < 12; i++) begin
      m = $urandom;
      ev = 9'($urandom);
      @(posedge pclk);
      slot_counter <= 4'($urandom);
      in_event <= 1'($urandom);
      acc(1, 32'h4000000C, m, 33'h0);
      acc(0, 32'h4000000C, 0, {1'b0, m & 32'hFFFF81FF});
      pulse(ev);
      ev[0] = ev[0] & m[16 + slot_counter] & (m[15] | ~in_event);
      acc(0, 32'h40000014, 0, {24'h0, ev});
      acc(0, 32'h40000010, 0, {24'h0, ev & m[8:0]});
      chk({32'h0, irq}, {32'h0, |(ev & m[8:0])});
      // Masking hides status but must keep the raw flags
      acc(1, 32'h4000000C, 0, 33'h0);
      acc(0, 32'h40000010, 0, 33'h0);
      chk({32'h0, irq}, 33'h0);
      acc(0, 32'h40000014, 0, {24'h0, ev});
      acc(1, 32'h40000018, 32'h1FF, 33'h0);
      acc(0, 32'h40000014, 0, 33'h0);
    end
    stop_test();
  end
endmodule // ble_core_irq_and_config_tb
`default_nettype wire
